//--- rtl/lane_agg_pkg.sv
// How it works
// - tx lanes: optional word align, decode, bypassable
// - each tx lane has its own phase FIFO
// - word mode: ten bits per lane per turn
// - bit mode: one bit per lane, cycling
// - aggregate optionally encoded and scrambled
// - configurable order of encode and scramble
// - scramble-first leaves control codes untouched
// - receive data aligned to 20-bit boundaries
// - align on code, or arbitrary boundary
// - receive boundary can be slipped manually
// - optional decode or descramble after alignment
// - each rx lane has its own FIFO
// - per-lane programmable rx skew delay
// - optional per-lane encode on rx output
// - rx one-to-one: no skew, no descrambler, lane0
// - tx search character replaced by marker
// - rx marker position sets lane assignment
// - rx marker optionally replaced before output
// - idle insert/delete, insert only after idle
// - fill on empty lane, rx fill monitors
// - tx one-to-one uses lane 0 only
package lane_agg_pkg;
  localparam int LANES = 8;
  localparam int WORD_W = 10;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ALIGN  = 8'h04;
  localparam logic [7:0] OFF_TXMARK = 8'h08;
  localparam logic [7:0] OFF_RXMARK = 8'h0C;
  localparam logic [7:0] OFF_IDLE   = 8'h10;
  localparam logic [7:0] OFF_SKEW   = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam int CB_TX_ALIGN = 0;
  localparam int CB_TX_DEC   = 1;
  localparam int CB_TX_CTC   = 2;
  localparam int CB_BIT_MODE = 3;
  localparam int CB_HS_ENC   = 4;
  localparam int CB_SCR      = 5;
  localparam int CB_SCR_1ST  = 6;
  localparam int CB_TX_MARK  = 7;
  localparam int CB_TX_1TO1  = 8;
  localparam int CB_RX_ALIGN = 9;
  localparam int CB_RX_DEC   = 10;
  localparam int CB_RX_DESCR = 11;
  localparam int CB_RX_CTC   = 12;
  localparam int CB_RX_MARK  = 13;
  localparam int CB_RX_REPL  = 14;
  localparam int CB_RX_ENC   = 15;
  localparam int CB_RX_1TO1  = 16;
  localparam int CB_SLIP     = 17;
  localparam int CTRL_W      = 17;
  localparam int HI_FIELD    = 16;
  localparam logic [16:0] CTRL_RST  = 17'h00000;
  localparam logic [9:0] ALIGN_RST  = 10'h0FA;
  localparam logic [9:0] SEARCH_RST = 10'h0FA;
  localparam logic [9:0] MARK_RST   = 10'h0F9;
  localparam logic [9:0] IDLE_RST   = 10'h0FC;
  localparam logic [9:0] FILL_RST   = 10'h155;
  localparam logic [23:0] SKEW_RST  = 24'h000000;
  localparam logic [14:0] SCR_SEED = 15'h7FFF;
  localparam logic [5:0] K28_6B = 6'b001111;
  localparam logic [5:0] SIX_FLIP = 6'b111000;
  localparam logic [3:0] FOUR_FLIP = 4'b1100;
  localparam logic [4:0] K28_IDX = 5'h1C;
  localparam logic [5:0] SIX_TAB [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] FOUR_TAB [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
endpackage : lane_agg_pkg

//--- rtl/lane_aggregator.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module lane_fifo #(
  parameter int DEPTH = 8
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ctcEn,
  input  wire logic [9:0] idleChar,
  input  wire logic [9:0] fillChar,
  input  wire logic       wrEn,
  input  wire logic [9:0] wrData,
  input  wire logic       rdEn,
  output logic      [9:0] rdData
);
  localparam int AW = $clog2(DEPTH);
  logic [9:0]    mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          lastIdle_reg;
  logic          dropIdle;
  logic          doWr;
  logic          doRd;

  assign dropIdle = ctcEn && wrData == idleChar && cnt_reg >= (AW+1)'(DEPTH - 2);
  assign doWr = wrEn && !dropIdle && cnt_reg != (AW+1)'(DEPTH);
  assign doRd = rdEn && cnt_reg != '0;

  // empty: repeat idle after idle, else fill pattern
  always_comb begin
    if (cnt_reg != '0) begin
      rdData = mem[rp_reg];
    end else if (ctcEn && lastIdle_reg) begin
      rdData = idleChar;
    end else begin
      rdData = fillChar;
    end
  end

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wp_reg] <= wrData;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_reg       <= '0;
      rp_reg       <= '0;
      cnt_reg      <= '0;
      lastIdle_reg <= 1'b0;
    end else begin
      if (doWr) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (doRd) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(doWr) - (AW+1)'(doRd);
      if (rdEn) begin
        lastIdle_reg <= rdData == idleChar;
      end
    end
  end
endmodule : lane_fifo

module lane_aggregator
  import lane_agg_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int SKEW_MAX   = 7,
  parameter int RX_PACE    = 4,
  parameter int FILL_RUN   = 4
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [79:0] txLaneData,
  input  wire logic [7:0]  txLaneValid,
  output logic      [9:0]  hsTxWord,
  output logic             hsTxValid,
  input  wire logic [19:0] hsRxData,
  input  wire logic        hsRxValid,
  output logic      [79:0] rxLaneWord,
  output logic      [7:0]  rxLaneValid
);
  import lane_agg_pkg::*;

  logic [16:0] ctrl_reg;
  logic [9:0]  lsAlign_reg;
  logic [9:0]  hsAlign_reg;
  logic [9:0]  search_reg;
  logic [9:0]  txReplace_reg;
  logic [9:0]  rxMark_reg;
  logic [9:0]  rxReplace_reg;
  logic [9:0]  idle_reg;
  logic [9:0]  fill_reg;
  logic [23:0] skew_reg;
  logic        slip_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        apbDone;
  logic [31:0] readMux;
  logic [7:0]  laneDown;
  logic [2:0]  rot_reg;
  logic        ordered_reg;
  logic        rxLock_reg;
  logic [4:0]  rxOff_reg;

  function automatic logic [10:0] enc8b10b(input logic [8:0] kd, input logic rd);
    logic [5:0] six;
    logic [3:0] four;
    logic       rdMid;
    six = (kd[8] && kd[4:0] == K28_IDX) ? K28_6B : SIX_TAB[kd[4:0]];
    four = FOUR_TAB[kd[7:5]];
    if (rd && ($countones(six) != 3 || six == SIX_FLIP)) begin
      six = ~six;
    end
    rdMid = rd ^ ($countones(six) != 3);
    if (rdMid && ($countones(four) != 2 || four == FOUR_FLIP)) begin
      four = ~four;
    end
    return {rdMid ^ ($countones(four) != 2), six, four};
  endfunction : enc8b10b

  function automatic logic [8:0] dec8b10b(input logic [9:0] c);
    logic [8:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      if (c[9:4] == SIX_TAB[i] || c[9:4] == ~SIX_TAB[i]) begin
        r[4:0] = 5'(i);
      end
    end
    if (c[9:4] == K28_6B || c[9:4] == ~K28_6B) begin
      r[4:0] = K28_IDX;
      r[8]   = 1'b1;
    end
    for (int i = 0; i < 8; i++) begin
      if (c[3:0] == FOUR_TAB[i] || c[3:0] == ~FOUR_TAB[i]) begin
        r[7:5] = 3'(i);
      end
    end
    return r;
  endfunction : dec8b10b

  // returns next state and keystream, n bits consumed
  function automatic logic [34:0] keyStream(input logic [14:0] s, input int n);
    logic [19:0] ks;
    ks = '0;
    for (int i = 0; i < 20; i++) begin
      if (i < n) begin
        ks[i] = s[14];
        s = {s[13:0], s[14] ^ s[13]};
      end
    end
    return {s, ks};
  endfunction : keyStream

  function automatic logic addrHit(input logic [7:0] a);
    return a == OFF_CTRL || a == OFF_ALIGN || a == OFF_TXMARK || a == OFF_RXMARK ||
           a == OFF_IDLE || a == OFF_SKEW || a == OFF_STATUS;
  endfunction : addrHit

  // apb slave: one wait state, then answer
  assign apbDone = psel && penable && pready_reg;
  always_comb begin
    case (paddr)
      OFF_CTRL:   readMux = {15'h0000, ctrl_reg};
      OFF_ALIGN:  readMux = {6'h00, hsAlign_reg, 6'h00, lsAlign_reg};
      OFF_TXMARK: readMux = {6'h00, txReplace_reg, 6'h00, search_reg};
      OFF_RXMARK: readMux = {6'h00, rxReplace_reg, 6'h00, rxMark_reg};
      OFF_IDLE:   readMux = {6'h00, fill_reg, 6'h00, idle_reg};
      OFF_SKEW:   readMux = {8'h00, skew_reg};
      OFF_STATUS: readMux = {14'h0000, ordered_reg, rxOff_reg, rxLock_reg, rot_reg, laneDown};
      default:    readMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !addrHit(paddr);
      if (psel && penable && !pready_reg && !pwrite) begin
        prdata_reg <= readMux;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg      <= CTRL_RST;
      lsAlign_reg   <= ALIGN_RST;
      hsAlign_reg   <= ALIGN_RST;
      search_reg    <= SEARCH_RST;
      txReplace_reg <= MARK_RST;
      rxMark_reg    <= MARK_RST;
      rxReplace_reg <= SEARCH_RST;
      idle_reg      <= IDLE_RST;
      fill_reg      <= FILL_RST;
      skew_reg      <= SKEW_RST;
      slip_reg      <= 1'b0;
    end else begin
      slip_reg <= apbDone && pwrite && paddr == OFF_CTRL && pwdata[CB_SLIP];
      if (apbDone && pwrite) begin
        case (paddr)
          OFF_CTRL: ctrl_reg <= pwdata[CTRL_W-1:0];
          OFF_ALIGN: begin
            lsAlign_reg <= pwdata[9:0];
            hsAlign_reg <= pwdata[HI_FIELD +: 10];
          end
          OFF_TXMARK: begin
            search_reg    <= pwdata[9:0];
            txReplace_reg <= pwdata[HI_FIELD +: 10];
          end
          OFF_RXMARK: begin
            rxMark_reg    <= pwdata[9:0];
            rxReplace_reg <= pwdata[HI_FIELD +: 10];
          end
          OFF_IDLE: begin
            idle_reg <= pwdata[9:0];
            fill_reg <= pwdata[HI_FIELD +: 10];
          end
          OFF_SKEW: skew_reg <= pwdata[23:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------- transmit ----------------
  logic [9:0]       txHead [LANES];
  logic [LANES-1:0] txPop;
  logic [2:0]       txSlot_reg;
  logic [79:0]      frame_reg;
  logic [79:0]      frameNext;
  logic [9:0]       l0_reg;
  logic [9:0]       aggWord;
  logic [14:0]      txScr_reg;
  logic [34:0]      txKs;
  logic             txRd_reg;
  logic [10:0]      txEnc;
  logic [9:0]       preEnc;
  logic [9:0]       txOut;
  logic [9:0]       hsTxWord_reg;
  logic             hsTxValid_reg;

  for (genvar l = 0; l < LANES; l++) begin : gTx
    logic [9:0]  prev_reg;
    logic [3:0]  off_reg;
    logic        lock_reg;
    logic [19:0] hist;
    logic [9:0]  laneWord;
    logic        wrEn;
    assign hist = {txLaneData[l*10 +: 10], prev_reg};
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        prev_reg <= 10'h000;
        off_reg  <= 4'h0;
        lock_reg <= 1'b0;
      end else if (!ctrl_reg[CB_TX_ALIGN]) begin
        lock_reg <= 1'b0;
        off_reg  <= 4'h0;
        if (txLaneValid[l]) begin
          prev_reg <= txLaneData[l*10 +: 10];
        end
      end else if (txLaneValid[l]) begin
        prev_reg <= txLaneData[l*10 +: 10];
        for (int o = 0; o < 10; o++) begin
          if (!lock_reg && hist[o +: 10] == lsAlign_reg) begin
            off_reg  <= 4'(o);
            lock_reg <= 1'b1;
          end
        end
      end
    end
    always_comb begin
      laneWord = hist[off_reg +: 10];
      if (ctrl_reg[CB_TX_DEC]) begin
        laneWord = {1'b0, dec8b10b(laneWord)};
      end
      if (ctrl_reg[CB_TX_MARK] && laneWord == search_reg) begin
        laneWord = txReplace_reg;
      end
    end
    assign wrEn = txLaneValid[l] && (lock_reg || !ctrl_reg[CB_TX_ALIGN]) &&
                  (!ctrl_reg[CB_TX_1TO1] || l == 0);
    assign txPop[l] = ctrl_reg[CB_TX_1TO1] ? (l == 0) : (txSlot_reg == 3'h7);
    lane_fifo #(.DEPTH(FIFO_DEPTH)) uFifo (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ctcEn    (ctrl_reg[CB_TX_CTC]),
      .idleChar (idle_reg),
      .fillChar (fill_reg),
      .wrEn     (wrEn),
      .wrData   (laneWord),
      .rdEn     (txPop[l]),
      .rdData   (txHead[l])
    );
  end

  // all eight slots every frame, empty lanes carry fill
  always_comb begin
    for (int b = 0; b < 80; b++) begin
      if (ctrl_reg[CB_BIT_MODE]) begin
        frameNext[b] = txHead[b % LANES][b / LANES];
      end else begin
        frameNext[b] = txHead[b / WORD_W][b % WORD_W];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txSlot_reg <= 3'h0;
      frame_reg  <= '0;
      l0_reg     <= 10'h000;
    end else begin
      txSlot_reg <= txSlot_reg + 3'h1;
      l0_reg     <= txHead[0];
      if (txSlot_reg == 3'h7) begin
        frame_reg <= frameNext;
      end
    end
  end

  assign aggWord = ctrl_reg[CB_TX_1TO1] ? l0_reg : frame_reg[txSlot_reg*10 +: 10];
  assign txKs = keyStream(txScr_reg, WORD_W);

  always_comb begin
    preEnc = aggWord;
    if (ctrl_reg[CB_SCR] && ctrl_reg[CB_SCR_1ST] && !aggWord[8]) begin
      preEnc[7:0] = aggWord[7:0] ^ txKs[7:0];
    end
    txEnc = enc8b10b(preEnc[8:0], txRd_reg);
    txOut = ctrl_reg[CB_HS_ENC] ? txEnc[9:0] : preEnc;
    if (ctrl_reg[CB_SCR] && !ctrl_reg[CB_SCR_1ST]) begin
      txOut = txOut ^ txKs[9:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txScr_reg     <= SCR_SEED;
      txRd_reg      <= 1'b0;
      hsTxWord_reg  <= 10'h000;
      hsTxValid_reg <= 1'b0;
    end else begin
      txScr_reg     <= txKs[34:20];
      hsTxWord_reg  <= txOut;
      hsTxValid_reg <= 1'b1;
      if (ctrl_reg[CB_HS_ENC]) begin
        txRd_reg <= txEnc[10];
      end
    end
  end

  // ---------------- receive ----------------
  logic [19:0]      rxPrev_reg;
  logic [39:0]      rxHist;
  logic [19:0]      rxAligned;
  logic [14:0]      rxScr_reg;
  logic [34:0]      rxKs;
  logic [9:0]       rxW [2];
  logic [1:0]       isMark;
  logic [2:0]       rxSlot_reg;
  logic [2:0]       laneOf [2];
  logic [LANES-1:0] rxWr;
  logic [9:0]       rxWrData [LANES];
  logic [$clog2(RX_PACE)-1:0] pace_reg;
  logic             tick;
  logic             rx1to1;
  logic [79:0]      rxLaneWord_reg;
  logic [7:0]       rxLaneValid_reg;

  assign rx1to1 = ctrl_reg[CB_RX_1TO1];
  assign rxHist = {hsRxData, rxPrev_reg};
  assign rxAligned = rxHist[rxOff_reg +: 20];
  assign rxKs = keyStream(rxScr_reg, 2 * WORD_W);
  assign tick = pace_reg == '0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxPrev_reg <= 20'h00000;
      rxOff_reg  <= 5'h00;
      rxLock_reg <= 1'b0;
    end else begin
      if (hsRxValid) begin
        rxPrev_reg <= hsRxData;
      end
      if (slip_reg) begin
        rxOff_reg <= (rxOff_reg == 5'h13) ? 5'h00 : rxOff_reg + 5'h01;
      end else if (!ctrl_reg[CB_RX_ALIGN]) begin
        rxLock_reg <= 1'b1;
      end else if (hsRxValid && !rxLock_reg) begin
        for (int o = 0; o < 20; o++) begin
          if (rxHist[o +: 10] == hsAlign_reg) begin
            rxOff_reg  <= 5'(o);
            rxLock_reg <= 1'b1;
          end
        end
      end
    end
  end

  for (genvar j = 0; j < 2; j++) begin : gRxWord
    logic [9:0] x;
    logic       descr;
    always_comb begin
      descr = ctrl_reg[CB_RX_DESCR] && !rx1to1;
      x = rxAligned[j*10 +: 10];
      if (descr && !ctrl_reg[CB_SCR_1ST]) begin
        x = x ^ rxKs[j*10 +: 10];
      end
      if (ctrl_reg[CB_RX_DEC]) begin
        x = {1'b0, dec8b10b(x)};
      end
      if (descr && ctrl_reg[CB_SCR_1ST] && !x[8]) begin
        x[7:0] = x[7:0] ^ rxKs[j*10 +: 8];
      end
      isMark[j] = ctrl_reg[CB_RX_MARK] && x == rxMark_reg;
      rxW[j] = (isMark[j] && ctrl_reg[CB_RX_REPL]) ? rxReplace_reg : x;
      laneOf[j] = rxSlot_reg + 3'(j) - rot_reg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxScr_reg   <= SCR_SEED;
      rxSlot_reg  <= 3'h0;
      rot_reg     <= 3'h0;
      ordered_reg <= 1'b0;
      pace_reg    <= '0;
    end else begin
      pace_reg <= (32'(pace_reg) == RX_PACE - 1) ? '0 : pace_reg + 1'b1;
      if (hsRxValid && rxLock_reg) begin
        rxScr_reg  <= rxKs[34:20];
        rxSlot_reg <= rxSlot_reg + 3'h2;
        if (isMark[1]) begin
          rot_reg     <= rxSlot_reg + 3'h1;
          ordered_reg <= 1'b1;
        end else if (isMark[0]) begin
          rot_reg     <= rxSlot_reg;
          ordered_reg <= 1'b1;
        end
      end
    end
  end

  for (genvar l = 0; l < LANES; l++) begin : gRx
    logic [9:0] head;
    logic [9:0] skew [SKEW_MAX];
    logic [9:0] tap;
    logic [2:0] sel;
    logic [10:0] enc;
    logic       rd_reg;
    logic [$clog2(FILL_RUN+1)-1:0] fillCnt_reg;
    always_comb begin
      rxWr[l] = 1'b0;
      rxWrData[l] = rxW[0];
      if (hsRxValid && rxLock_reg) begin
        if (rx1to1) begin
          rxWr[l] = (l == 0);
        end else if (laneOf[0] == 3'(l)) begin
          rxWr[l] = 1'b1;
        end else if (laneOf[1] == 3'(l)) begin
          rxWr[l] = 1'b1;
          rxWrData[l] = rxW[1];
        end
      end
    end
    lane_fifo #(.DEPTH(FIFO_DEPTH)) uFifo (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ctcEn    (ctrl_reg[CB_RX_CTC]),
      .idleChar (idle_reg),
      .fillChar (fill_reg),
      .wrEn     (rxWr[l]),
      .wrData   (rxWrData[l]),
      .rdEn     (tick),
      .rdData   (head)
    );
    assign sel = skew_reg[l*3 +: 3];
    assign tap = (rx1to1 || sel == 3'h0) ? head : skew[sel - 3'h1];
    assign enc = enc8b10b(tap[8:0], rd_reg);
    assign laneDown[l] = 32'(fillCnt_reg) == FILL_RUN;
    always_ff @(posedge clk) begin
      if (tick) begin
        skew[0] <= head;
        for (int s = 1; s < SKEW_MAX; s++) begin
          skew[s] <= skew[s-1];
        end
      end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        rd_reg              <= 1'b0;
        fillCnt_reg         <= '0;
        rxLaneWord_reg[l*10 +: 10] <= 10'h000;
        rxLaneValid_reg[l]  <= 1'b0;
      end else begin
        rxLaneValid_reg[l] <= tick && (!rx1to1 || l == 0);
        if (tick) begin
          rxLaneWord_reg[l*10 +: 10] <= ctrl_reg[CB_RX_ENC] ? enc[9:0] : tap;
          if (ctrl_reg[CB_RX_ENC]) begin
            rd_reg <= enc[10];
          end
        end
        if (rxWr[l]) begin
          if (rxWrData[l] != fill_reg) begin
            fillCnt_reg <= '0;
          end else if (!laneDown[l]) begin
            fillCnt_reg <= fillCnt_reg + 1'b1;
          end
        end
      end
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign hsTxWord    = hsTxWord_reg;
  assign hsTxValid   = hsTxValid_reg;
  assign rxLaneWord  = rxLaneWord_reg;
  assign rxLaneValid = rxLaneValid_reg;
endmodule : lane_aggregator

//--- tb/lane_aggregator_checker.sv
`timescale 1ns/1ps
module lane_aggregator_checker
  import lane_agg_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        hsTxValid,
  input wire logic [7:0]  rxLaneValid
);
  logic [1:0] relCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // cycles since reset release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) relCnt <= 2'h0;
    else if (relCnt != 2'h3) relCnt <= relCnt + 2'h1;
  end
  sequence accWait; psel && penable && !pready; endsequence
  sequence accDone; psel && penable && pready; endsequence
  ready_on_time_a: assert property (accWait |=> accDone) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  ready_cause_a: assert property (pready |-> psel && penable) else $error("pready unasked");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  unmapped_err_a: assert property (accDone and paddr > OFF_STATUS |-> pslverr)
    else $error("unmapped no error");
  mapped_ok_a: assert property (pready && paddr <= OFF_STATUS && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped error");
  err_data_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("error data");
  tx_run_a: assert property (relCnt != 2'h0 |-> hsTxValid) else $error("tx gap");
  rx_pace_a: assert property (rxLaneValid[0] |=> !rxLaneValid[0] [*3])
    else $error("rx pace");
endmodule : lane_aggregator_checker

bind lane_aggregator lane_aggregator_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hsTxValid(hsTxValid), .rxLaneValid(rxLaneValid));

//--- tb/peer_aggregator.sv
`timescale 1ns/1ps
module peer_aggregator (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  output logic      [19:0] hsRxData,
  output logic             hsRxValid
);
  logic [19:0] pend[$];
  // one pair every other cycle, changing pattern when idle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hsRxValid <= 1'b0;
      hsRxData  <= 20'h00000;
    end else if (pend.size() > 0 && !hsRxValid) begin
      hsRxData  <= pend.pop_front();
      hsRxValid <= 1'b1;
    end else begin
      hsRxValid <= 1'b0;
      hsRxData  <= ~hsRxData;
    end
  end
  // slot pairs, lower word first
  task automatic sendFrame(input logic [79:0] f);
    for (int i = 0; i < 4; i++) pend.push_back(f[i*20+:20]);
  endtask : sendFrame
endmodule : peer_aggregator

//--- tb/serial_lane_aggregation_datapath_tb_top.sv
`timescale 1ns/1ps
module serial_lane_aggregation_datapath_tb_top;
  import lane_agg_pkg::*;
  localparam logic [7:0]  RW_ADDR [4] = '{OFF_ALIGN, OFF_TXMARK, OFF_RXMARK, OFF_SKEW};
  localparam logic [31:0] RW_MASK [4] = '{32'h03FF03FF, 32'h03FF03FF, 32'h03FF03FF,
                                          32'h00FFFFFF};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [79:0] txLaneData = '0;
  logic [7:0]  txLaneValid = 8'h00;
  logic [9:0]  hsTxWord;
  logic        hsTxValid;
  logic [19:0] hsRxData;
  logic        hsRxValid;
  logic [79:0] rxLaneWord;
  logic [7:0]  rxLaneValid;
  int          mismatches = 0;
  int          samples_checked = 0;
  integer      seed = 76505;
  logic [32:0] apbExp[$];
  logic [32:0] txExp[$];
  logic [32:0] rxExp[8][$];
  logic [79:0] f;
  logic [31:0] d;
  always #20 clk = ~clk;
  lane_aggregator u_dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txLaneData(txLaneData), .txLaneValid(txLaneValid),
    .hsTxWord(hsTxWord), .hsTxValid(hsTxValid), .hsRxData(hsRxData),
    .hsRxValid(hsRxValid), .rxLaneWord(rxLaneWord), .rxLaneValid(rxLaneValid));
  peer_aggregator u_peer (.clk(clk), .sys_rst(sys_rst), .hsRxData(hsRxData),
    .hsRxValid(hsRxValid));
  task automatic conclude;
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     input logic [32:0] e);
    int n;
    apbExp.push_back(e);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic txRound(input logic [79:0] fr);
    txLaneData <= fr;
    txLaneValid <= 8'hFF;
    @(posedge clk);
    txLaneValid <= 8'h00;
    repeat (7) @(posedge clk);
  endtask : txRound
  task automatic drain;
    int n, left;
    for (n = 0; n < 400; n++) begin
      left = txExp.size();
      foreach (rxExp[l]) left += rxExp[l].size();
      if (left == 0) return;
      @(posedge clk);
    end
    mismatches++;
    conclude();
  endtask : drain
  // scoreboard: data words carry bit 9, fill and idle do not
  always @(posedge clk) begin
    if (psel && penable && pready && apbExp.size() > 0)
      check({pslverr, pwrite ? 32'h00000000 : prdata}, apbExp.pop_front());
    if (hsTxValid && hsTxWord[9] && txExp.size() > 0)
      check({23'h000000, hsTxWord}, txExp.pop_front());
    for (int l = 0; l < 8; l++)
      if (rxLaneValid[l] && rxLaneWord[l*10+9] && rxExp[l].size() > 0)
        check({23'h000000, rxLaneWord[l*10+:10]}, rxExp[l].pop_front());
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(OFF_CTRL, 1'b0, 32'h00000000, {16'h0000, CTRL_RST});
    apb(OFF_IDLE, 1'b0, 32'h00000000, {7'h00, FILL_RST, 6'h00, IDLE_RST});
    apb(OFF_SKEW, 1'b0, 32'h00000000, {9'h000, SKEW_RST});
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      apb(RW_ADDR[i], 1'b1, d, 33'h000000000);
      apb(RW_ADDR[i], 1'b0, 32'h00000000, {1'b0, d & RW_MASK[i]});
    end
    apb(8'h1C, 1'b0, 32'h00000000, 33'h100000000);
    apb(8'h40, 1'b1, 32'hFFFFFFFF, 33'h100000000);
    // word interleave, random lane words
    for (int r = 0; r < 6; r++) begin
      for (int l = 0; l < 8; l++) begin
        f[l*10+:10] = {1'b1, 9'($random(seed))};
        txExp.push_back({23'h000000, f[l*10+:10]});
      end
      txRound(f);
    end
    txRound('0);
    txRound('0);
    drain();
    // zero fill keeps empty bit frames free of bit 9
    apb(OFF_IDLE, 1'b1, 32'h000000FC, 33'h000000000);
    // bit interleave: lane words 3FE give slot 0 300, others 3FF
    apb(OFF_CTRL, 1'b1, 32'h00000008, 33'h000000000);
    for (int r = 0; r < 3; r++) begin
      txExp.push_back(33'h000000300);
      repeat (7) txExp.push_back(33'h0000003FF);
      txRound({8{10'h3FE}});
    end
    txRound('0);
    drain();
    // receive: marker in lane 0 orders lanes, replaced on output
    apb(OFF_RXMARK, 1'b1, 32'h02F900F9, 33'h000000000);
    apb(OFF_CTRL, 1'b1, 32'h00006000, 33'h000000000);
    // first marker lands before the rotation is known
    rxExp[2].push_back(33'h0000002F9);
    u_peer.sendFrame({70'h0, 10'h0F9});
    for (int r = 0; r < 6; r++) begin
      for (int l = 0; l < 8; l++) begin
        f[l*10+:10] = (l == 0) ? 10'h0F9 : {1'b1, 9'($random(seed))};
        rxExp[l].push_back({23'h000000, (l == 0) ? 10'h2F9 : f[l*10+:10]});
      end
      u_peer.sendFrame(f);
      repeat (8) @(posedge clk);
    end
    u_peer.sendFrame('0);
    drain();
    conclude();
  end
endmodule : serial_lane_aggregation_datapath_tb_top
